// ### design/uart_ctl_map.vh
`ifndef UART_CTL_MAP_VH
`define UART_CTL_MAP_VH

// register index as printed; byte address is four times it
`define CTL_REG_INDEX    14'hf43
`define CTL_BYTE_ADDR    {`CTL_REG_INDEX, 2'b00}

// view select codes
`define VIEW_FILTER      3'h1
`define VIEW_BUS         3'h2

// filter view fields
`define FLT_ON_BIT       7
`define FLT_WSEL_HI      6
`define FLT_WSEL_LO      4

// bus view fields
`define BUS_MASTER_BIT   7
`define BUS_FOLLOW_BIT   6
`define RATE_ON_BIT      5
`define RATE_IRQ_BIT     4
`define STATE_HI         3
`define STATE_LO         2
`define BRK_HI           1
`define BRK_LO           0

// reset values
`define CTL_RESET        8'h00
`define FLT_WSEL_RESET   3'h0
`define STATE_RESET      2'h0
`define BRK_RESET        2'h0

// bus state encoding
`define ST_SLEEP         2'h0
`define ST_WAIT_BREAK    2'h1
`define ST_RATE_DETECT   2'h2
`define ST_ACTIVE        2'h3

// break length in bit times, base plus code
`define BRK_BASE_BITS    5'h0d

// filter counter width at code zero
`define FLT_MIN_WIDTH    4'h4

`endif

// ### design/rx_noise_filter.v
`timescale 1ns/100ps
`default_nettype none

`include "uart_ctl_map.vh"

module rx_noise_filter #(
  parameter MAX_WIDTH = 11
) (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       clkEn,
  input  wire       filterOn,
  input  wire [2:0] widthSel,
  input  wire       rxIn,
  output reg        rxOut
);

  reg  [MAX_WIDTH-1:0] count_r;
  wire [MAX_WIDTH-1:0] limit;

  // all-ones value of a counter of the selected width
  function [MAX_WIDTH-1:0] countLimit;
    input [2:0] sel;
    reg   [3:0] w;
    begin
      w = `FLT_MIN_WIDTH + {1'b0, sel};
      countLimit = ~({MAX_WIDTH{1'b1}} << w);
    end
  endfunction

  assign limit = countLimit(widthSel);

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (reset) begin
      count_r <= {MAX_WIDTH{1'b0}};
      rxOut   <= 1'b1;
    end else if (clkEn) begin
      if (!filterOn) begin
        count_r <= rxIn ? limit : {MAX_WIDTH{1'b0}};
        rxOut   <= rxIn;
      end else if (count_r > limit) begin
        // width shrunk under a running count: clamp, keep output
        count_r <= limit;
      end else begin
        if (rxIn && count_r != limit)
          count_r <= count_r + {{(MAX_WIDTH-1){1'b0}}, 1'b1};
        else if (!rxIn && count_r != {MAX_WIDTH{1'b0}})
          count_r <= count_r - {{(MAX_WIDTH-1){1'b0}}, 1'b1};
        // output flips only at the ends, wider count means longer delay
        if (count_r == limit)
          rxOut <= 1'b1;
        else if (count_r == {MAX_WIDTH{1'b0}})
          rxOut <= 1'b0;
      end
    end
  end

endmodule // rx_noise_filter

`default_nettype wire

// ### design/two_entry_buffer.v
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output reg              inReady,
  output reg  [WIDTH-1:0] outData,
  output reg              outValid,
  input  wire             outReady
);

  reg [WIDTH-1:0] spare_r;
  reg             spareValid_r;
  wire            push;
  wire            pop;

  assign push = inValid & inReady;
  assign pop  = outValid & outReady;

  ////////////////////////////////////////////////////////////////////////////////
  // outData is the head, spare_r the second slot; all outputs are flops
  always @(posedge clk_sys) begin
    if (reset) begin
      outData      <= {WIDTH{1'b0}};
      outValid     <= 1'b0;
      spare_r      <= {WIDTH{1'b0}};
      spareValid_r <= 1'b0;
      inReady      <= 1'b1;
    end else if (clkEn) begin
      if (pop) begin
        if (spareValid_r) begin
          outData      <= spare_r;
          outValid     <= 1'b1;
          spareValid_r <= push;
          spare_r      <= inData;
          inReady      <= ~push;
        end else begin
          outData  <= inData;
          outValid <= push;
          inReady  <= 1'b1;
        end
      end else if (push) begin
        if (outValid) begin
          spare_r      <= inData;
          spareValid_r <= 1'b1;
          inReady      <= 1'b0;
        end else begin
          outData  <= inData;
          outValid <= 1'b1;
        end
      end
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// ### design/uart_second_ctl.v
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none

`include "uart_ctl_map.vh"

module uart_second_ctl #(
  parameter FILTER_MAX_WIDTH = 11,
  parameter BYTE_WIDTH       = 8
) (
  input  wire                  clk_sys,
  input  wire                  reset,
  input  wire                  clkEn,
  // apb slave
  input  wire [15:0]           paddr,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // from the rest of the uart
  input  wire [2:0]            viewSelectField,
  input  wire                  nineBitModeOn,
  input  wire                  parityOn,
  input  wire                  bitTick,
  input  wire                  breakRequest,
  input  wire                  breakSeen,
  input  wire                  rateCharSeen,
  input  wire                  doneFlagClear,
  // serial line
  input  wire                  rxIn,
  output wire                  rxFiltered,
  output reg                   txBreakActive,
  output reg                   breakDone,
  // role and state
  output reg                   masterActive,
  output reg                   followerActive,
  output reg                   rateDetectActive,
  output reg                   rateDetectIrq,
  output reg                   rateDetectDoneFlag,
  output reg  [1:0]            serialBusState,
  // received byte stream
  input  wire [BYTE_WIDTH-1:0] rxByte,
  input  wire                  rxByteValid,
  output wire                  rxByteReady,
  output wire [BYTE_WIDTH-1:0] byteOut,
  output wire                  byteOutValid,
  input  wire                  byteOutReady
);

  localparam BRK_IDLE = 2'b01;
  localparam BRK_SEND = 2'b10;

  reg        filterOn_r;
  reg  [2:0] filterWidthSel_r;
  reg        busMasterSel_r;
  reg        busFollowerSel_r;
  reg        rateDetectOn_r;
  reg        rateDetectIrqOn_r;
  reg  [1:0] breakDurationSel_r;
  reg  [1:0] state_nxt;
  reg  [1:0] brkState_r;
  reg  [4:0] brkCount_r;
  reg  [7:0] viewData;

  wire       setup;
  wire       access;
  wire       addrHit;
  wire       viewMapped;
  wire       regWrite;
  wire       stateWrite;
  wire       masterOk;
  wire       followerOk;
  wire [4:0] breakBits;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode; answer one cycle into the access phase

  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign addrHit    = (paddr == `CTL_BYTE_ADDR);
  assign viewMapped = (viewSelectField == `VIEW_FILTER) | (viewSelectField == `VIEW_BUS);
  assign regWrite   = access & pready & pwrite & addrHit & ~pslverr;
  assign stateWrite = regWrite & (viewSelectField == `VIEW_BUS);

  always @* begin
    viewData = `CTL_RESET;
    if (viewSelectField == `VIEW_FILTER) begin
      viewData[`FLT_ON_BIT]                = filterOn_r;
      viewData[`FLT_WSEL_HI:`FLT_WSEL_LO] = filterWidthSel_r;
    end else if (viewSelectField == `VIEW_BUS) begin
      viewData[`BUS_MASTER_BIT]   = busMasterSel_r;
      viewData[`BUS_FOLLOW_BIT]   = busFollowerSel_r;
      viewData[`RATE_ON_BIT]      = rateDetectOn_r;
      viewData[`RATE_IRQ_BIT]     = rateDetectIrqOn_r;
      viewData[`STATE_HI:`STATE_LO] = serialBusState;
      viewData[`BRK_HI:`BRK_LO]   = breakDurationSel_r;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      if (access & ~pready) begin
        pready  <= 1'b1;
        pslverr <= ~(addrHit & viewMapped);
        prdata  <= (addrHit & viewMapped) ? {24'h00_0000, viewData} : 32'h0000_0000;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        if (setup)
          prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control fields; the two views keep separate storage

  always @(posedge clk_sys) begin
    if (reset) begin
      filterOn_r         <= 1'b0;
      filterWidthSel_r   <= `FLT_WSEL_RESET;
      busMasterSel_r     <= 1'b0;
      busFollowerSel_r   <= 1'b0;
      rateDetectOn_r     <= 1'b0;
      rateDetectIrqOn_r  <= 1'b0;
      breakDurationSel_r <= `BRK_RESET;
    end else if (clkEn & regWrite) begin
      if (viewSelectField == `VIEW_FILTER) begin
        filterOn_r       <= pwdata[`FLT_ON_BIT];
        filterWidthSel_r <= pwdata[`FLT_WSEL_HI:`FLT_WSEL_LO];
      end else begin
        busMasterSel_r     <= pwdata[`BUS_MASTER_BIT];
        busFollowerSel_r   <= pwdata[`BUS_FOLLOW_BIT];
        rateDetectOn_r     <= pwdata[`RATE_ON_BIT];
        rateDetectIrqOn_r  <= pwdata[`RATE_IRQ_BIT];
        breakDurationSel_r <= pwdata[`BRK_HI:`BRK_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // roles

  assign masterOk   = busMasterSel_r & ~busFollowerSel_r & ~nineBitModeOn & ~parityOn;
  assign followerOk = busFollowerSel_r & ~busMasterSel_r & ~nineBitModeOn & ~parityOn;

  always @(posedge clk_sys) begin
    if (reset) begin
      masterActive   <= 1'b0;
      followerActive <= 1'b0;
    end else if (clkEn) begin
      masterActive   <= masterOk;
      followerActive <= followerOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus state field, shared by software and hardware

  always @* begin
    state_nxt = serialBusState;
    if (stateWrite) begin
      // software write forces the state, beating hardware
      state_nxt = pwdata[`STATE_HI:`STATE_LO];
    end else if (followerOk) begin
      case (serialBusState)
        `ST_WAIT_BREAK: begin
          if (breakSeen)
            state_nxt = `ST_RATE_DETECT;
        end
        `ST_RATE_DETECT: begin
          // no measurement wanted: skip straight on
          if (rateCharSeen | ~rateDetectOn_r)
            state_nxt = `ST_ACTIVE;
        end
        default: state_nxt = serialBusState;
      endcase
    end
    // master: no hardware moves, active holds until software writes another state
  end

  always @(posedge clk_sys) begin
    if (reset)
      serialBusState <= `STATE_RESET;
    else if (clkEn)
      serialBusState <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // rate detection and its interrupt

  always @(posedge clk_sys) begin
    if (reset) begin
      rateDetectActive   <= 1'b0;
      rateDetectIrq      <= 1'b0;
      rateDetectDoneFlag <= 1'b0;
    end else if (clkEn) begin
      // measurement only for an enabled follower in the detect state
      rateDetectActive <= followerOk & rateDetectOn_r & (state_nxt == `ST_RATE_DETECT);
      // irq pulse and sticky done flag
      rateDetectIrq <= followerOk & rateDetectOn_r & rateDetectIrqOn_r & rateCharSeen
                       & (serialBusState == `ST_RATE_DETECT);
      // set beats a clear in the same cycle
      if (followerOk & rateDetectOn_r & rateDetectIrqOn_r & rateCharSeen
          & (serialBusState == `ST_RATE_DETECT))
        rateDetectDoneFlag <= 1'b1;
      else if (doneFlagClear)
        rateDetectDoneFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // master break transmitter

  assign breakBits = `BRK_BASE_BITS + {3'b000, breakDurationSel_r};

  always @(posedge clk_sys) begin
    if (reset) begin
      brkState_r    <= BRK_IDLE;
      brkCount_r    <= 5'h00;
      txBreakActive <= 1'b0;
      breakDone     <= 1'b0;
    end else if (clkEn) begin
      breakDone <= 1'b0;
      case (brkState_r)
        BRK_IDLE: begin
          // break only from an active master
          if (breakRequest & masterOk & (serialBusState == `ST_ACTIVE)) begin
            brkState_r    <= BRK_SEND;
            brkCount_r    <= breakBits;
            txBreakActive <= 1'b1;
          end
        end
        BRK_SEND: begin
          // count bit ticks down; length latched at start
          if (bitTick) begin
            if (brkCount_r == 5'h01) begin
              brkState_r    <= BRK_IDLE;
              txBreakActive <= 1'b0;
              breakDone     <= 1'b1;
            end
            brkCount_r <= brkCount_r - 5'h01;
          end
        end
        default: begin
          brkState_r    <= BRK_IDLE;
          txBreakActive <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive line filter and byte buffer

  rx_noise_filter #(
    .MAX_WIDTH (FILTER_MAX_WIDTH)
  ) u_filter (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .filterOn (filterOn_r),
    .widthSel (filterWidthSel_r),
    .rxIn     (rxIn),
    .rxOut    (rxFiltered)
  );

  // a stall downstream backs up into rxByteReady, no word lost
  two_entry_buffer #(
    .WIDTH (BYTE_WIDTH)
  ) u_buffer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .inData   (rxByte),
    .inValid  (rxByteValid),
    .inReady  (rxByteReady),
    .outData  (byteOut),
    .outValid (byteOutValid),
    .outReady (byteOutReady)
  );

endmodule // uart_second_ctl

`default_nettype wire

// ### verification/uart_second_ctl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module uart_second_ctl_asserts #(
  parameter FILTER_MAX_WIDTH = 11,
  parameter BYTE_WIDTH       = 8
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [15:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  viewSelectField,
  input wire logic        nineBitModeOn,
  input wire logic        parityOn,
  input wire logic        bitTick,
  input wire logic        breakRequest,
  input wire logic        rateCharSeen,
  input wire logic        txBreakActive,
  input wire logic        breakDone,
  input wire logic        masterActive,
  input wire logic        followerActive,
  input wire logic        rateDetectIrq,
  input wire logic        rateDetectDoneFlag,
  input wire logic [1:0]  serialBusState
);
  // ticks seen while the break is driven
  logic [4:0] tickCnt_r;
  always_ff @(posedge clk_sys) begin
    if (reset || !txBreakActive) tickCnt_r <= 5'h00;
    else if (bitTick) tickCnt_r <= tickCnt_r + 5'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence sFirstAccess; psel && penable && !$past(penable); endsequence
  sequence sDone; psel && penable && pready; endsequence
  sequence sMapped; paddr == 16'h3d0c && viewSelectField inside {3'h1, 3'h2}; endsequence
  sequence sUnmapped; paddr != 16'h3d0c || !(viewSelectField inside {3'h1, 3'h2}); endsequence
  a_one_wait: assert property (sFirstAccess |-> !pready ##1 pready) else $error("pready not after one wait");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_unmapped: assert property (sDone ##0 sUnmapped |-> pslverr && prdata == 32'h0)
    else $error("bad access not refused");
  a_ok_mapped: assert property (sDone ##0 sMapped |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("mapped access refused");
  a_rsvd_zero: assert property (sDone ##0 (!pwrite && viewSelectField == 3'h1) |-> prdata[3:0] == 4'h0)
    else $error("reserved filter bits not zero");
  a_master_qual: assert property (masterActive |->
    !$past(nineBitModeOn) && !$past(parityOn) && !followerActive) else $error("master role not qualified");
  a_follow_qual: assert property (followerActive |-> !$past(nineBitModeOn) && !$past(parityOn))
    else $error("follower role not qualified");
  a_irq_cause: assert property (rateDetectIrq |-> $past(rateCharSeen) && $past(followerActive)
    && $past(serialBusState) == 2'h2 && rateDetectDoneFlag) else $error("irq without cause");
  a_break_start: assert property (breakRequest && masterActive && serialBusState == 2'h3 && !txBreakActive
    |=> txBreakActive) else $error("break not started");
  a_break_range: assert property (breakDone |-> !txBreakActive && tickCnt_r >= 5'h0d && tickCnt_r <= 5'h10)
    else $error("break length out of range");
  a_master_hold: assert property (masterActive && $past(masterActive) && !$past(pready && pwrite)
    |-> $stable(serialBusState)) else $error("master state moved by hardware");
endmodule // uart_second_ctl_asserts
bind uart_second_ctl uart_second_ctl_asserts #(.FILTER_MAX_WIDTH(FILTER_MAX_WIDTH), .BYTE_WIDTH(BYTE_WIDTH)) u_chk (
  .clk_sys, .reset, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .viewSelectField,
  .nineBitModeOn, .parityOn, .bitTick, .breakRequest, .rateCharSeen, .txBreakActive, .breakDone,
  .masterActive, .followerActive, .rateDetectIrq, .rateDetectDoneFlag, .serialBusState);
`default_nettype wire

// ### verification/line_peer.sv
`timescale 1ns/100ps
`default_nettype none
module line_peer (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        glitchGo,
  input wire logic [11:0] glitchLen,
  input wire logic        stall,
  input wire logic        txBreakActive,
  input wire logic        breakDone,
  input wire logic [7:0]  byteOut,
  input wire logic        byteOutValid,
  output logic            rxIn,
  output logic            bitTick,
  output logic            byteOutReady,
  output logic [4:0]      brkBits
);
  logic [11:0] lowCnt_r;
  logic [1:0]  phase_r;
  logic [4:0]  tickCnt_r;
  logic [7:0]  got[$];
  always @(posedge clk_sys) begin
    if (reset) begin
      lowCnt_r <= 12'h000;
      phase_r <= 2'h0;
      tickCnt_r <= 5'h00;
      brkBits <= 5'h00;
    end else begin
      lowCnt_r <= glitchGo ? glitchLen : (lowCnt_r != 12'h000 ? lowCnt_r - 12'h001 : 12'h000);
      phase_r <= txBreakActive ? phase_r + 2'h1 : 2'h0;
      tickCnt_r <= txBreakActive ? tickCnt_r + {4'h0, bitTick} : 5'h00;
      if (breakDone) brkBits <= tickCnt_r;
      if (byteOutValid && byteOutReady) got.push_back(byteOut);
    end
  end
  // line has a pull-up: idle high
  assign rxIn = (lowCnt_r == 12'h000);
  // bit times only run while the line is held in break
  assign bitTick = txBreakActive && phase_r == 2'h3;
  assign byteOutReady = !stall;
endmodule // line_peer
`default_nettype wire

// ### verification/uart_second_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module uart_second_ctl_tb;
  logic clk_sys = 0, reset = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [2:0] viewSelectField = 3'h0;
  logic nineBitModeOn = 0, parityOn = 0, bitTick, breakRequest = 0, breakSeen = 0, rateCharSeen = 0;
  logic doneFlagClear = 0, rxIn, rxFiltered, txBreakActive, breakDone, masterActive, followerActive;
  logic rateDetectActive, rateDetectIrq, rateDetectDoneFlag, rxByteValid = 0, rxByteReady, byteOutValid;
  logic byteOutReady, rerr, glitchGo = 0, stall = 0;
  logic [1:0] serialBusState;
  logic [7:0] rxByte = 8'ha0, byteOut;
  logic [11:0] glitchLen = 12'h0;
  logic [4:0] brkBits;
  int n_mismatch = 0, checked = 0, i;
  typedef struct packed {logic [2:0] v; logic [15:0] a; logic [7:0] wd, rd; logic er;} row_t;
  row_t rows[6] = '{'{3'h1, 16'h3d0c, 8'hff, 8'hf0, 1'b0}, '{3'h2, 16'h3d0c, 8'h03, 8'h03, 1'b0},
    '{3'h1, 16'h3d0c, 8'h00, 8'h00, 1'b0}, '{3'h2, 16'h3d0c, 8'h00, 8'h00, 1'b0},
    '{3'h3, 16'h3d0c, 8'h55, 8'h00, 1'b1}, '{3'h1, 16'h3d04, 8'h55, 8'h00, 1'b1}};
  always #2 clk_sys = ~clk_sys;
  uart_second_ctl u_dut (.clk_sys, .reset, .clkEn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .viewSelectField, .nineBitModeOn, .parityOn, .bitTick, .breakRequest, .breakSeen,
    .rateCharSeen, .doneFlagClear, .rxIn, .rxFiltered, .txBreakActive, .breakDone, .masterActive,
    .followerActive, .rateDetectActive, .rateDetectIrq, .rateDetectDoneFlag, .serialBusState, .rxByte,
    .rxByteValid, .rxByteReady, .byteOut, .byteOutValid, .byteOutReady);
  line_peer u_peer (.clk_sys, .reset, .glitchGo, .glitchLen, .stall, .txBreakActive, .breakDone, .byteOut,
    .byteOutValid, .rxIn, .bitTick, .byteOutReady, .brkBits);
  always @(posedge clk_sys) if (rxByteValid && rxByteReady) begin
    rxByte <= rxByte + 8'h01;
    if (rxByte == 8'ha3) rxByteValid <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // held until pready is sampled high, released after
  task apb(input logic [2:0] v, input logic w, input logic [15:0] a, input logic [7:0] d);
    // start on an edge even when the caller has just sampled off it
    @(posedge clk_sys);
    viewSelectField <= v; psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk_sys) penable <= 1;
    // only the watchdog ends a wait that never completes
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata; rerr = pslverr; psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [2:0] v, input logic [7:0] exp);
    apb(v, 1'b0, 16'h3d0c, 8'h00);
    chk("ctl", rdat, {24'h0, exp});
  endtask
  task glitch(input logic [11:0] len, input logic exp);
    glitchGo <= 1; glitchLen <= len;
    @(posedge clk_sys) glitchGo <= 0;
    repeat (len) @(posedge clk_sys);
    #1 chk("rxFiltered", 32'(rxFiltered), 32'(exp));
    repeat (40) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin #60000 n_mismatch++; close_out; end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h00);
    $display("reset values done");
    foreach (rows[r]) begin
      apb(rows[r].v, 1'b1, rows[r].a, rows[r].wd);
      apb(rows[r].v, 1'b0, rows[r].a, 8'h00);
      chk("rdata", rdat, {24'h0, rows[r].rd});
      chk("pslverr", 32'(rerr), 32'(rows[r].er));
    end
    $display("register table done");
    glitch(12'h001, 1'b0);
    apb(3'h1, 1'b1, 16'h3d0c, 8'h80);
    glitch(12'h00a, 1'b1);
    glitch(12'h01e, 1'b0);
    apb(3'h1, 1'b1, 16'h3d0c, 8'hf0);
    repeat (2100) @(posedge clk_sys);
    glitch(12'h01e, 1'b1);
    $display("filter done");
    for (i = 0; i < 4; i++) begin
      apb(3'h2, 1'b1, 16'h3d0c, 8'h8c | 8'(i));
      repeat (2) @(posedge clk_sys);
      #1 chk("masterActive", 32'(masterActive), 32'h1);
      @(posedge clk_sys) breakRequest <= 1;
      @(posedge clk_sys) breakRequest <= 0;
      #1 chk("txBreakActive", 32'(txBreakActive), 32'h1);
      do @(posedge clk_sys); while (breakDone !== 1'b1);
      #1 chk("brkBits", 32'(brkBits), 32'(13 + i));
      chk("txBreakActive", 32'(txBreakActive), 32'h0);
    end
    rd(3'h2, 8'h8f);
    parityOn <= 1;
    repeat (2) @(posedge clk_sys);
    #1 chk("masterActive", 32'(masterActive), 32'h0);
    @(posedge clk_sys) parityOn <= 0;
    $display("master done");
    apb(3'h2, 1'b1, 16'h3d0c, 8'h74);
    repeat (2) @(posedge clk_sys);
    #1 chk("followerActive", 32'(followerActive), 32'h1);
    @(posedge clk_sys) breakSeen <= 1;
    @(posedge clk_sys) breakSeen <= 0;
    #1 chk("rateDetectActive", 32'(rateDetectActive), 32'h1);
    rd(3'h2, 8'h78);
    rateCharSeen <= 1;
    @(posedge clk_sys) rateCharSeen <= 0;
    #1 chk("irq", 32'(rateDetectIrq), 32'h1);
    chk("doneFlag", 32'(rateDetectDoneFlag), 32'h1);
    rd(3'h2, 8'h7c);
    doneFlagClear <= 1;
    @(posedge clk_sys) doneFlagClear <= 0;
    #1 chk("doneFlag", 32'(rateDetectDoneFlag), 32'h0);
    apb(3'h2, 1'b1, 16'h3d0c, 8'h70);
    rd(3'h2, 8'h70);
    apb(3'h2, 1'b1, 16'h3d0c, 8'h64);
    breakSeen <= 1;
    @(posedge clk_sys) breakSeen <= 0;
    rateCharSeen <= 1;
    @(posedge clk_sys) rateCharSeen <= 0;
    #1 chk("irq", 32'(rateDetectIrq | rateDetectDoneFlag), 32'h0);
    rd(3'h2, 8'h6c);
    nineBitModeOn <= 1;
    repeat (2) @(posedge clk_sys);
    #1 chk("followerActive", 32'(followerActive), 32'h0);
    // clock enable low: the role must not follow its inputs
    @(posedge clk_sys) clkEn <= 0;
    nineBitModeOn <= 0;
    repeat (3) @(posedge clk_sys);
    #1 chk("followerActive", 32'(followerActive), 32'h0);
    @(posedge clk_sys) clkEn <= 1;
    repeat (2) @(posedge clk_sys);
    #1 chk("followerActive", 32'(followerActive), 32'h1);
    $display("follower done");
    // far side stalls: two words held, none lost
    @(posedge clk_sys) stall <= 1;
    rxByteValid <= 1;
    repeat (6) @(posedge clk_sys);
    #1 chk("rxByteReady", 32'(rxByteReady), 32'h0);
    chk("byteOut", 32'(byteOut), 32'ha0);
    @(posedge clk_sys) stall <= 0;
    repeat (10) @(posedge clk_sys);
    chk("words", 32'(u_peer.got.size()), 32'h4);
    foreach (u_peer.got[w]) chk("word", 32'(u_peer.got[w]), 32'(8'ha0 + 8'(w)));
    $display("buffer done");
    close_out;
  end
endmodule // uart_second_ctl_tb
`default_nettype wire
